/* rtl/cgo_clkdiv.sv */
module cgo_clkdiv #(
    parameter int CNT_W = 15
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       src_edge,
    input  wire logic [3:0] ratio_log,
    output logic            clk_q
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] term;

    // Toggling once per 2^k source edges gives one period per 2^k periods.
    assign term = CNT_W'((32'h1 << ratio_log) - 32'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (src_edge) begin
            if (count >= term) begin
                count <= '0;
            end else begin
                count <= count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_q <= 1'b0;
        end else if (src_edge && count >= term) begin
            clk_q <= ~clk_q;
        end
    end

endmodule

/* rtl/cgo_top.sv */
module cgo_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        internal_osc_clock,
    input  wire logic        low_speed_osc_clock,
    input  wire logic        high_speed_osc_clock,
    input  wire logic        standby_active,
    input  wire logic        low_osc_stop_evt,
    input  wire logic        autotrim_done_evt,
    input  wire logic        high_osc_stable_evt,
    input  wire logic        low_osc_stable_evt,
    input  wire logic        int_osc_stable_evt,
    input  wire logic [4:0]  factory_high_trim,
    input  wire logic [5:0]  factory_int_trim,
    output logic [4:0]       high_osc_trim,
    output logic [5:0]       int_osc_trim,
    output logic             divided_clock_output,
    output logic             clock_irq
);

    cgo_pkg::cgo_bus_t       bus_state;
    logic [11:0]             xfer_addr;
    logic                    accept;
    logic                    wr_now;
    logic [cgo_pkg::IRQ_W-1:0] osc_irq_enable;
    logic [cgo_pkg::IRQ_W-1:0] osc_irq_flags;
    logic [cgo_pkg::IRQ_W-1:0] evt_vec;
    logic [cgo_pkg::IRQ_W-1:0] clr_vec;
    logic                    out_clock_enable;
    logic [1:0]              out_clock_source;
    logic [2:0]              out_clock_divider;
    logic                    trim_loaded;
    logic [2:0]              osc_meta;
    logic [2:0]              osc_sync;
    logic [2:0]              osc_last;
    logic [2:0]              osc_edge;
    logic                    src_edge;
    logic                    div_clk;
    logic                    sys_frozen;

    // Register decoding that the read path and write path share.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    function automatic logic [3:0] ratio_log(input logic [1:0] src,
                                             input logic [2:0] div);
        ratio_log = {1'b0, div};
        if (src == cgo_pkg::SRC_SYS) begin
            ratio_log = 4'h0;
        end else if (src == cgo_pkg::SRC_LOW) begin
            case (div)
                3'h4:    ratio_log = cgo_pkg::LOW_LOG_4;
                3'h5:    ratio_log = cgo_pkg::LOW_LOG_5;
                3'h6:    ratio_log = cgo_pkg::LOW_LOG_6;
                3'h7:    ratio_log = cgo_pkg::LOW_LOG_7;
                default: ratio_log = {1'b0, div};
            endcase
        end
    endfunction

    // Bus slave: zero-wait writes, one wait state on every read.
    assign accept = hsel && htrans[1] && hready;
    assign wr_now = (bus_state == cgo_pkg::BUS_WRITE);
    assign hreadyout = (bus_state != cgo_pkg::BUS_RD_WAIT);
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= cgo_pkg::BUS_IDLE;
            xfer_addr <= 12'h000;
        end else begin
            case (bus_state)
                cgo_pkg::BUS_RD_WAIT: begin
                    bus_state <= cgo_pkg::BUS_RD_DATA;
                end
                cgo_pkg::BUS_IDLE, cgo_pkg::BUS_WRITE,
                cgo_pkg::BUS_RD_DATA: begin
                    if (accept) begin
                        xfer_addr <= haddr[11:0];
                        bus_state <= hwrite ? cgo_pkg::BUS_WRITE
                                            : cgo_pkg::BUS_RD_WAIT;
                    end else begin
                        bus_state <= cgo_pkg::BUS_IDLE;
                    end
                end
                default: bus_state <= cgo_pkg::BUS_IDLE;
            endcase
        end
    end

    // Read data is taken after any write ahead of it has landed.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_state == cgo_pkg::BUS_RD_WAIT) begin
            hrdata <= 32'h0000_0000;
            if (hit(xfer_addr, cgo_pkg::OFS_IRQ_EN)) begin
                hrdata[cgo_pkg::IRQ_W-1:0] <= osc_irq_enable;
            end else if (hit(xfer_addr, cgo_pkg::OFS_IRQ_FLAGS)) begin
                hrdata[cgo_pkg::IRQ_W-1:0] <= osc_irq_flags;
            end else if (hit(xfer_addr, cgo_pkg::OFS_OUT_CTRL)) begin
                hrdata[cgo_pkg::POS_OUT_EN]  <= out_clock_enable;
                hrdata[cgo_pkg::POS_OUT_SRC +: 2] <= out_clock_source;
                hrdata[cgo_pkg::POS_OUT_DIV +: 3] <= out_clock_divider;
            end else if (hit(xfer_addr, cgo_pkg::OFS_TRIM)) begin
                hrdata[cgo_pkg::POS_HIGH_TRIM +: cgo_pkg::HIGH_TRIM_W]
                    <= high_osc_trim;
                hrdata[cgo_pkg::POS_INT_TRIM +: cgo_pkg::INT_TRIM_W]
                    <= int_osc_trim;
            end
        end
    end

    // Interrupt enables; reserved bits stay zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_irq_enable <= cgo_pkg::IRQ_EN_RST;
        end else if (wr_now && hit(xfer_addr, cgo_pkg::OFS_IRQ_EN)) begin
            osc_irq_enable <= hwdata[cgo_pkg::IRQ_W-1:0]
                              & cgo_pkg::IRQ_IMPL_MASK;
        end
    end

    assign evt_vec = {low_osc_stop_evt, autotrim_done_evt, 1'b0,
                      high_osc_stable_evt, low_osc_stable_evt,
                      int_osc_stable_evt};
    assign clr_vec = (wr_now && hit(xfer_addr, cgo_pkg::OFS_IRQ_FLAGS))
                     ? hwdata[cgo_pkg::IRQ_W-1:0] : '0;

    // Sticky flags; a new event wins over a clear in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_irq_flags <= cgo_pkg::IRQ_FLAG_RST;
        end else begin
            osc_irq_flags <= ((osc_irq_flags & ~clr_vec) | evt_vec)
                             & cgo_pkg::IRQ_IMPL_MASK;
        end
    end

    assign clock_irq = |(osc_irq_flags & osc_irq_enable);

    // Output control register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_clock_enable  <= cgo_pkg::OUT_EN_RST;
            out_clock_source  <= cgo_pkg::OUT_SRC_RST;
            out_clock_divider <= cgo_pkg::OUT_DIV_RST;
        end else if (wr_now && hit(xfer_addr, cgo_pkg::OFS_OUT_CTRL)) begin
            out_clock_enable  <= hwdata[cgo_pkg::POS_OUT_EN];
            out_clock_source  <= hwdata[cgo_pkg::POS_OUT_SRC +: 2];
            out_clock_divider <= hwdata[cgo_pkg::POS_OUT_DIV +: 3];
        end
    end

    // Trims take the factory values on the first edge after reset.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_loaded   <= 1'b0;
            high_osc_trim <= cgo_pkg::HIGH_TRIM_RST;
            int_osc_trim  <= cgo_pkg::INT_TRIM_RST;
        end else if (!trim_loaded) begin
            trim_loaded   <= 1'b1;
            high_osc_trim <= factory_high_trim;
            int_osc_trim  <= factory_int_trim;
        end else if (wr_now && hit(xfer_addr, cgo_pkg::OFS_TRIM)) begin
            high_osc_trim <= hwdata[cgo_pkg::POS_HIGH_TRIM +:
                                    cgo_pkg::HIGH_TRIM_W];
            int_osc_trim  <= hwdata[cgo_pkg::POS_INT_TRIM +:
                                    cgo_pkg::INT_TRIM_W];
        end
    end

    // Oscillator clocks are synchronised, then both edges are counted.
    for (genvar g = 0; g < 3; g++) begin : g_osc_sync
        logic osc_in;
        if (g == 0) begin : g_int
            assign osc_in = internal_osc_clock;
        end else if (g == 1) begin : g_low
            assign osc_in = low_speed_osc_clock;
        end else begin : g_high
            assign osc_in = high_speed_osc_clock;
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                osc_meta[g] <= 1'b0;
                osc_sync[g] <= 1'b0;
                osc_last[g] <= 1'b0;
            end else begin
                osc_meta[g] <= osc_in;
                osc_sync[g] <= osc_meta[g];
                osc_last[g] <= osc_sync[g];
            end
        end
        assign osc_edge[g] = osc_sync[g] ^ osc_last[g];
    end

    // The system clock stops in standby, so its edges stop too.
    assign sys_frozen = (out_clock_source == cgo_pkg::SRC_SYS)
                        && standby_active;

    always_comb begin
        case (out_clock_source)
            cgo_pkg::SRC_INT:  src_edge = osc_edge[0];
            cgo_pkg::SRC_LOW:  src_edge = osc_edge[1];
            cgo_pkg::SRC_HIGH: src_edge = osc_edge[2];
            default:           src_edge = !sys_frozen;
        endcase
    end

    cgo_clkdiv #(
        .CNT_W     (cgo_pkg::DIV_CNT_W)
    ) u_div (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .src_edge  (src_edge),
        .ratio_log (ratio_log(out_clock_source, out_clock_divider)),
        .clk_q     (div_clk)
    );

    // The gate is applied straight away, whatever the clock phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divided_clock_output <= 1'b0;
        end else begin
            divided_clock_output <= out_clock_enable & div_clk;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_read_start;
        accept && !hwrite && bus_state != cgo_pkg::BUS_RD_WAIT;
    endsequence

    sequence s_read_finish;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait_state: assert property (s_read_start |=> s_read_finish)
        else $error("read did not take exactly one wait state");

    a_irq_level_match: assert property (
        |(evt_vec & osc_irq_enable)
        && !(wr_now && hit(xfer_addr, cgo_pkg::OFS_IRQ_EN))
        |=> clock_irq)
        else $error("enabled event did not raise the interrupt");

    a_flag_event_set: assert property (
        low_osc_stop_evt |=> osc_irq_flags[cgo_pkg::BIT_LOW_STOP])
        else $error("stop event did not set its flag");

    a_flag_w1c_clear: assert property (
        wr_now && hit(xfer_addr, cgo_pkg::OFS_IRQ_FLAGS)
        && hwdata[cgo_pkg::BIT_AUTOTRIM] && !autotrim_done_evt
        |=> !osc_irq_flags[cgo_pkg::BIT_AUTOTRIM])
        else $error("writing one did not clear the flag");

    a_flag_zero_hold: assert property (
        osc_irq_flags[cgo_pkg::BIT_INT_STABLE]
        && !(clr_vec[cgo_pkg::BIT_INT_STABLE])
        |=> osc_irq_flags[cgo_pkg::BIT_INT_STABLE])
        else $error("flag dropped without a clearing write");

    a_enable_gates_irq: assert property (
        osc_irq_flags[cgo_pkg::BIT_HIGH_STABLE]
        && osc_irq_enable[cgo_pkg::BIT_HIGH_STABLE] |-> clock_irq)
        else $error("enabled flag did not raise the interrupt");

    a_out_disabled_low: assert property (
        !out_clock_enable [*2] |-> !divided_clock_output)
        else $error("output pin moved while disabled");

    a_sleep_holds_pin: assert property (
        sys_frozen [*3] |-> $stable(divided_clock_output))
        else $error("system clock output toggled in standby");

    a_sys_undivided: assert property (
        out_clock_enable && out_clock_source == cgo_pkg::SRC_SYS
        && !standby_active && $stable(out_clock_source)
        ##1 out_clock_enable
        |=> divided_clock_output != $past(divided_clock_output))
        else $error("system clock output is not undivided");

    a_trim_factory: assert property (
        !trim_loaded |=> high_osc_trim == $past(factory_high_trim)
                         && int_osc_trim == $past(factory_int_trim))
        else $error("trim did not take the factory value");

endmodule

/* shared/cgo_pkg.sv */
package cgo_pkg;

    // Register byte offsets on the bus.
    localparam logic [11:0] OFS_IRQ_EN    = 12'h000;
    localparam logic [11:0] OFS_IRQ_FLAGS = 12'h004;
    localparam logic [11:0] OFS_OUT_CTRL  = 12'h008;
    localparam logic [11:0] OFS_TRIM      = 12'h00c;

    // Event bit positions, shared by the flag and enable registers.
    localparam int IRQ_W           = 6;
    localparam int BIT_LOW_STOP    = 5;
    localparam int BIT_AUTOTRIM    = 4;
    localparam int BIT_HIGH_STABLE = 2;
    localparam int BIT_LOW_STABLE  = 1;
    localparam int BIT_INT_STABLE  = 0;
    localparam logic [IRQ_W-1:0] IRQ_IMPL_MASK = 6'h37;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST    = 6'h00;
    localparam logic [IRQ_W-1:0] IRQ_FLAG_RST  = 6'h00;

    // Output control register fields.
    localparam int POS_OUT_EN  = 0;
    localparam int POS_OUT_SRC = 2;
    localparam int POS_OUT_DIV = 4;
    localparam logic       OUT_EN_RST  = 1'b0;
    localparam logic [1:0] OUT_SRC_RST = 2'h0;
    localparam logic [2:0] OUT_DIV_RST = 3'h0;

    // Output clock sources.
    localparam logic [1:0] SRC_INT  = 2'h0;
    localparam logic [1:0] SRC_LOW  = 2'h1;
    localparam logic [1:0] SRC_HIGH = 2'h2;
    localparam logic [1:0] SRC_SYS  = 2'h3;

    // Log2 of the low-speed ratios for division codes 4 to 7.
    localparam logic [3:0] LOW_LOG_4 = 4'h8;
    localparam logic [3:0] LOW_LOG_5 = 4'ha;
    localparam logic [3:0] LOW_LOG_6 = 4'hc;
    localparam logic [3:0] LOW_LOG_7 = 4'hf;
    localparam int         DIV_CNT_W = 15;

    // Trim register fields.
    localparam int HIGH_TRIM_W   = 5;
    localparam int INT_TRIM_W    = 6;
    localparam int POS_HIGH_TRIM = 8;
    localparam int POS_INT_TRIM  = 0;
    localparam logic [HIGH_TRIM_W-1:0] HIGH_TRIM_RST = 5'h00;
    localparam logic [INT_TRIM_W-1:0]  INT_TRIM_RST  = 6'h00;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_RD_WAIT,
        BUS_RD_DATA
    } cgo_bus_t;

endpackage

/* sim/cgo_pin_watch.sv */
module cgo_pin_watch (
    input  wire logic        hclk,
    input  wire logic        pin,
    output logic [31:0]      period,
    output logic [31:0]      rises
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        prev = 1'b0;
    logic [31:0] cnt  = 32'h0;

    initial period = 32'h0;
    initial rises  = 32'h0;

    // Receiver only listens; it measures hclk cycles between rising edges.
    always @(posedge hclk) begin
        prev <= pin;
        if (pin === 1'b1 && prev === 1'b0) begin
            period <= cnt;
            rises  <= rises + 32'h1;
            cnt    <= 32'h1;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end
endmodule

/* sim/clock_gen_output_and_trim_tb_top.sv */
module clock_gen_output_and_trim_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        i_clk = 1'b0;
    logic        l_clk = 1'b0;
    logic        h_clk = 1'b0;
    logic        osc_run = 1'b1;
    int          ph = 0;
    logic        standby = 1'b0;
    logic [5:0]  evt = 6'h0;
    logic [4:0]  fac_high = 5'h0;
    logic [5:0]  fac_int = 6'h0;
    logic [4:0]  high_trim;
    logic [5:0]  int_trim;
    logic        pin;
    logic        irq;
    logic [31:0] period;
    logic [31:0] rises;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [31:0] rd;
    logic [5:0]  en;
    logic [10:0] tv;

    always #5 hclk = ~hclk;

    // Oscillator stand-ins: half periods of 2, 4 and 3 hclk cycles.
    always @(posedge hclk) begin
        if (osc_run) begin
            ph <= ph + 1;
            if (ph % 2 == 0) i_clk <= ~i_clk;
            if (ph % 4 == 0) l_clk <= ~l_clk;
            if (ph % 3 == 0) h_clk <= ~h_clk;
        end
    end

    cgo_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .internal_osc_clock(i_clk),
        .low_speed_osc_clock(l_clk), .high_speed_osc_clock(h_clk),
        .standby_active(standby), .low_osc_stop_evt(evt[5]),
        .autotrim_done_evt(evt[4]), .high_osc_stable_evt(evt[2]),
        .low_osc_stable_evt(evt[1]), .int_osc_stable_evt(evt[0]),
        .factory_high_trim(fac_high), .factory_int_trim(fac_int),
        .high_osc_trim(high_trim), .int_osc_trim(int_trim),
        .divided_clock_output(pin), .clock_irq(irq)
    );

    cgo_pin_watch rx (
        .hclk(hclk), .pin(pin), .period(period), .rises(rises)
    );

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
        // The write lands at the edge just seen; let it settle.
        @(negedge hclk);
    endtask

    task automatic rd_check(input string what, input logic [11:0] a,
                            input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(what, exp, r);
        check("response", 32'h0, {31'h0, hresp});
    endtask

    // Pin period in hclk cycles for a source and division code.
    function automatic logic [31:0] exp_period(input logic [1:0] s,
                                               input logic [2:0] d);
        int lg;
        int half;
        lg = d;
        half = (s == 2'h0) ? 2 : (s == 2'h1) ? 4 : 3;
        if (s == 2'h3) return 32'h2;
        if (s == 2'h1 && d >= 3'h4) lg = (d == 3'h4) ? 8 : (d == 3'h5) ? 10
                                       : (d == 3'h6) ? 12 : 15;
        return 32'(2 * half) << lg;
    endfunction

    task automatic pin_test(input logic [1:0] s, input logic [2:0] d);
        logic [31:0] r0;
        int          n;
        wr(cgo_pkg::OFS_OUT_CTRL, {25'h0, d, s, 2'b01});
        r0 = rises;
        n = 0;
        while (rises < r0 + 32'h3 && n < 40000) begin
            @(posedge hclk);
            n++;
        end
        check("pin period", exp_period(s, d), period);
    endtask

    initial begin
        void'($urandom(32'h419d7e7e));
        fac_high <= 5'($urandom);
        fac_int  <= 6'($urandom);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_check("enable reset", cgo_pkg::OFS_IRQ_EN, 32'h0);
        rd_check("flags reset", cgo_pkg::OFS_IRQ_FLAGS, 32'h0);
        rd_check("ctrl reset", cgo_pkg::OFS_OUT_CTRL, 32'h0);
        rd_check("trim reset", cgo_pkg::OFS_TRIM,
                 {19'h0, fac_high, 2'h0, fac_int});
        check("pin idle", 32'h0, {31'h0, pin});
        $display("reset values done");

        wr(cgo_pkg::OFS_IRQ_EN, 32'hffff_ffff);
        rd_check("enable bits", cgo_pkg::OFS_IRQ_EN, 32'h37);
        wr(cgo_pkg::OFS_OUT_CTRL, 32'hffff_fff2);
        rd_check("ctrl bits", cgo_pkg::OFS_OUT_CTRL, 32'h70);
        wr(12'h010, 32'hffff_ffff);
        rd_check("unmapped", 12'h010, 32'h0);
        $display("register map done");

        for (int b = 0; b < 6; b++) begin
            if (b == 3) continue;
            en = 6'($urandom) & 6'h37;
            wr(cgo_pkg::OFS_IRQ_EN, {26'h0, en});
            @(posedge hclk);
            evt[b] <= 1'b1;
            @(posedge hclk);
            evt[b] <= 1'b0;
            rd_check("flag set", cgo_pkg::OFS_IRQ_FLAGS, 32'h1 << b);
            check("irq level", {31'h0, en[b]}, {31'h0, irq});
            wr(cgo_pkg::OFS_IRQ_EN, 32'h1 << b);
            check("irq unmasked", 32'h1, {31'h0, irq});
            wr(cgo_pkg::OFS_IRQ_FLAGS, ~(32'h1 << b));
            rd_check("flag kept", cgo_pkg::OFS_IRQ_FLAGS, 32'h1 << b);
            wr(cgo_pkg::OFS_IRQ_EN, 32'h0);
            check("irq masked", 32'h0, {31'h0, irq});
            wr(cgo_pkg::OFS_IRQ_FLAGS, 32'h1 << b);
            rd_check("flag clear", cgo_pkg::OFS_IRQ_FLAGS, 32'h0);
            check("irq idle", 32'h0, {31'h0, irq});
        end
        $display("interrupt events done");

        for (int t = 0; t < 3; t++) begin
            tv = 11'($urandom);
            if (t == 1) tv = 11'h7ff;
            if (t == 2) tv = 11'h000;
            osc_run <= 1'b0;
            wr(cgo_pkg::OFS_TRIM, {19'h7ffff, tv[10:6], 2'h3, tv[5:0]});
            rd_check("trim read", cgo_pkg::OFS_TRIM,
                     {19'h0, tv[10:6], 2'h0, tv[5:0]});
            check("high trim", {27'h0, tv[10:6]}, {27'h0, high_trim});
            check("int trim", {26'h0, tv[5:0]}, {26'h0, int_trim});
        end
        osc_run <= 1'b1;
        $display("trim done");

        for (int d = 0; d < 8; d++) begin
            pin_test(2'h0, 3'(d));
            pin_test(2'h2, 3'(d));
            if (d < 5) pin_test(2'h1, 3'(d));
        end
        pin_test(2'h3, 3'h0);
        $display("pin divider done");

        standby <= 1'b1;
        repeat (4) @(posedge hclk);
        rd = rises;
        repeat (30) @(posedge hclk);
        check("standby rises", rd, rises);
        standby <= 1'b0;
        repeat (8) @(posedge hclk);
        check("wake period", 32'h2, period);
        wr(cgo_pkg::OFS_OUT_CTRL, 32'h0c);
        repeat (4) @(posedge hclk);
        rd = rises;
        repeat (40) @(posedge hclk);
        check("disabled rises", rd, rises);
        check("disabled pin", 32'h0, {31'h0, pin});
        $display("standby and disable done");
        report_and_stop();
    end

    initial begin
        #900000;
        miscompares++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
